// >>> design/lse_defines.svh
// Register addresses, field positions, reset values and timing counts for the LIN flag block.
`ifndef LSE_DEFINES_SVH
`define LSE_DEFINES_SVH

`define LSE_ADDR_W 8
`define LSE_DATA_W 8

`define LSE_ADDR_CTRL 8'h08
`define LSE_ADDR_STATUS 8'h09
`define LSE_ADDR_ERR 8'h0a

`define LSE_CTRL_STOP 7
`define LSE_CTRL_DATA_ACKNOWLEDGE_BIT 4
`define LSE_CTRL_INTERRUPT_RESET_BIT 3
`define LSE_CTRL_ERROR_RESET_BIT 2

`define LSE_ST_DATA_REQUEST_FLAG 4
`define LSE_ST_INT 3
`define LSE_ST_ERROR 2
`define LSE_ST_WAKEUP 1
`define LSE_ST_DONE 0

`define LSE_ERR_SYNC 4
`define LSE_ERR_PARITY 3
`define LSE_ERR_TIMEOUT 2
`define LSE_ERR_CHECKSUM 1
`define LSE_ERR_BIT 0
`define LSE_ERR_FLAGS 5

`define LSE_RESET_BYTE 8'h00
`define LSE_MAX_FRAME_BITS 8'hae

`endif

// >>> design/lse_pkg.sv
// Types shared by the LIN status and error flag block.
package lse_pkg;
  typedef logic [7:0] lse_byte_t;
  typedef logic [4:0] lse_err_t;
  typedef enum logic [2:0] {
    LSE_IDLE = 3'b001,
    LSE_FRAME = 3'b010,
    LSE_LATE = 3'b100
  } lse_frame_state_t;
endpackage

// >>> design/lse_status_flags.sv
// Status and error flag logic of a LIN controller with its indirect register port.
`timescale 1ns/1ps
`include "lse_defines.svh"

module lse_status_flags
  import lse_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`LSE_ADDR_W-1:0] reg_addr,
  input wire logic [`LSE_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lse_byte_t reg_rdata,
  input wire logic slave_mode,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic bit_tick,
  input wire logic id_received,
  input wire logic first_byte_done,
  input wire logic ack_consumed,
  input wire logic irq_event,
  input wire logic tx_start,
  input wire logic tx_complete,
  input wire logic wakeup_tx_active,
  input wire logic wakeup_rx,
  input wire logic sync_tol_fail,
  input wire logic parity_fail,
  input wire logic master_no_response,
  input wire logic slave_no_data,
  input wire logic checksum_valid,
  input wire logic [7:0] checksum_received,
  input wire logic [7:0] checksum_computed,
  input wire logic tx_active,
  input wire logic bit_sample,
  input wire logic tx_bit,
  input wire logic lin_rx_pin,
  output logic data_acknowledge_bit,
  output logic stop_request,
  output logic lin_irq_pending
);

  logic rx_meta;
  logic rx_sync;
  logic wr_ctrl;
  logic error_reset_bit;
  logic interrupt_reset_bit;
  logic ack_or_stop_seen;
  logic data_request_flag;
  logic interrupt_pending_flag;
  logic comm_error;
  logic wakeup_seen;
  logic wakeup_status;
  logic done_flag;
  logic late_ack;
  logic frame_overrun;
  logic [7:0] frame_bits;
  lse_frame_state_t frame_state;
  lse_frame_state_t next_frame_state;
  lse_err_t err_set;
  lse_err_t err_q;
  lse_byte_t lin_error_flags;
  lse_byte_t lin_controller_status;
  lse_byte_t lin_control_reg;
  lse_byte_t next_rdata;

  // The bus pin is asynchronous to clk; only the second stage is used.
  always_ff @(posedge clk or negedge rst_n) begin
    // Reset to the recessive idle level so no false bit error follows reset.
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= lin_rx_pin;
      rx_sync <= rx_meta;
    end
  end

  assign wr_ctrl = reg_wr && (reg_addr == `LSE_ADDR_CTRL);
  // Reset bits act only on a write of one and are never stored.
  assign error_reset_bit = wr_ctrl && reg_wdata[`LSE_CTRL_ERROR_RESET_BIT];
  assign interrupt_reset_bit = wr_ctrl && reg_wdata[`LSE_CTRL_INTERRUPT_RESET_BIT];

  // Acknowledge is held until the frame engine consumes it or a frame starts; a new write wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_acknowledge_bit <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`LSE_CTRL_DATA_ACKNOWLEDGE_BIT]) begin
      data_acknowledge_bit <= 1'b1;
    end else if (ack_consumed || frame_start) begin
      data_acknowledge_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_request <= 1'b0;
    end else begin
      stop_request <= wr_ctrl && reg_wdata[`LSE_CTRL_STOP];
    end
  end

  // Remembers whether software answered the identifier with acknowledge or stop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_or_stop_seen <= 1'b0;
    end else if (wr_ctrl && (reg_wdata[`LSE_CTRL_DATA_ACKNOWLEDGE_BIT] || reg_wdata[`LSE_CTRL_STOP])) begin
      ack_or_stop_seen <= 1'b1;
    end else if (id_received) begin
      ack_or_stop_seen <= 1'b0;
    end
  end

  // The deadline is the end of the first byte after the identifier.
  assign late_ack = slave_mode && first_byte_done && !ack_or_stop_seen &&
    !(wr_ctrl && (reg_wdata[`LSE_CTRL_DATA_ACKNOWLEDGE_BIT] || reg_wdata[`LSE_CTRL_STOP]));

  // Frame length watchdog counted in bit times between start and end.
  always_comb begin
    next_frame_state = frame_state;
    unique case (frame_state)
      LSE_IDLE: begin
        if (frame_start) begin
          next_frame_state = LSE_FRAME;
        end
      end
      LSE_FRAME: begin
        if (frame_end) begin
          next_frame_state = LSE_IDLE;
        end else if (bit_tick && (frame_bits == `LSE_MAX_FRAME_BITS - 8'h01)) begin
          next_frame_state = LSE_LATE;
        end
      end
      LSE_LATE: begin
        if (frame_end || frame_start) begin
          next_frame_state = frame_start ? LSE_FRAME : LSE_IDLE;
        end
      end
      default: begin
        next_frame_state = LSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_state <= LSE_IDLE;
    end else begin
      frame_state <= next_frame_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_bits <= 8'h00;
    end else if (frame_start) begin
      frame_bits <= 8'h00;
    end else if (frame_state == LSE_FRAME && bit_tick) begin
      frame_bits <= frame_bits + 8'h01;
    end
  end

  assign frame_overrun = (frame_state == LSE_FRAME) && (next_frame_state == LSE_LATE);

  // Error event sources; sync, parity and the no-response sources are gated by the mode they apply in.
  always_comb begin
    err_set = 5'h00;
    err_set[`LSE_ERR_SYNC] = slave_mode && sync_tol_fail;
    err_set[`LSE_ERR_PARITY] = slave_mode && parity_fail;
    err_set[`LSE_ERR_TIMEOUT] = (!slave_mode && master_no_response) ||
      (slave_mode && slave_no_data) ||
      frame_overrun || late_ack;
    err_set[`LSE_ERR_CHECKSUM] = checksum_valid && (checksum_received != checksum_computed);
    // Synchronised bus level is compared with the driven bit at the sample point.
    err_set[`LSE_ERR_BIT] = tx_active && bit_sample && (rx_sync != tx_bit);
  end

  genvar gi;
  generate
    for (gi = 0; gi < `LSE_ERR_FLAGS; gi++) begin : g_err
      lse_sticky_flag u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .set(err_set[gi]),
        .clr(error_reset_bit),
        .q(err_q[gi])
      );
    end
  endgenerate

  // Aggregate error follows any individual flag event.
  lse_sticky_flag u_error (
    .clk(clk),
    .rst_n(rst_n),
    .set(|err_set),
    .clr(error_reset_bit),
    .q(comm_error)
  );

  // Pending interrupt gathers external requests, errors, requests and completion.
  lse_sticky_flag u_int (
    .clk(clk),
    .rst_n(rst_n),
    .set(irq_event || (|err_set) || tx_complete || (slave_mode && id_received)),
    .clr(interrupt_reset_bit),
    .q(interrupt_pending_flag)
  );

  // Data request lasts until acknowledged or a new frame begins.
  lse_sticky_flag u_dreq (
    .clk(clk),
    .rst_n(rst_n),
    .set(slave_mode && id_received),
    .clr(frame_start || (wr_ctrl && reg_wdata[`LSE_CTRL_DATA_ACKNOWLEDGE_BIT])),
    .q(data_request_flag)
  );

  // A received wakeup is remembered until the next frame starts.
  lse_sticky_flag u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .set(wakeup_rx),
    .clr(frame_start),
    .q(wakeup_seen)
  );

  assign wakeup_status = wakeup_tx_active || wakeup_seen;

  // Completion beats a start in the same cycle so a finish is never lost.
  lse_sticky_flag u_done (
    .clk(clk),
    .rst_n(rst_n),
    .set(tx_complete),
    .clr(tx_start),
    .q(done_flag)
  );

  assign lin_irq_pending = interrupt_pending_flag;

  // Upper bits are tied low; writes to this address are ignored.
  assign lin_error_flags = {3'b000, err_q};

  always_comb begin
    lin_controller_status = `LSE_RESET_BYTE;
    lin_controller_status[`LSE_ST_DATA_REQUEST_FLAG] = data_request_flag;
    lin_controller_status[`LSE_ST_INT] = interrupt_pending_flag;
    lin_controller_status[`LSE_ST_ERROR] = comm_error;
    lin_controller_status[`LSE_ST_WAKEUP] = wakeup_status;
    lin_controller_status[`LSE_ST_DONE] = done_flag;
  end

  // Reset bits and stop always read back as zero.
  always_comb begin
    lin_control_reg = `LSE_RESET_BYTE;
    lin_control_reg[`LSE_CTRL_DATA_ACKNOWLEDGE_BIT] = data_acknowledge_bit;
  end

  // Read data is registered so the port sees a stable byte one cycle after the strobe.
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `LSE_ADDR_CTRL: next_rdata = lin_control_reg;
        `LSE_ADDR_STATUS: next_rdata = lin_controller_status;
        `LSE_ADDR_ERR: next_rdata = lin_error_flags;
        default: next_rdata = `LSE_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `LSE_RESET_BYTE;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// >>> design/lse_sticky_flag.sv
// One sticky flag: an event sets it, a clear request resets it, and a set wins over a clear.
`timescale 1ns/1ps
module lse_sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // Set has priority so an event landing in the clearing cycle is kept.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule

// >>> test/lse_bus_node.sv
// Far-side LIN node model that echoes the driven bit or overrides it.
`timescale 1ns/1ps
module lse_bus_node (
  input wire logic tx_active,
  input wire logic tx_bit,
  input wire logic corrupt,
  output logic lin_rx_pin
);
  // Nobody drives an idle bus, so the pull-up leaves it recessive high.
  assign lin_rx_pin = tx_active ? (tx_bit ^ corrupt) : 1'b1;
endmodule

// >>> test/lse_monitor.sv
// Concurrent checks on the ports of the LIN status and error flag block.
`timescale 1ns/1ps
module lse_monitor
  import lse_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input lse_byte_t reg_rdata,
  input wire logic irq_event,
  input wire logic ack_consumed,
  input wire logic data_acknowledge_bit,
  input wire logic stop_request,
  input wire logic lin_irq_pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic ctrl_wr;
  assign ctrl_wr = reg_wr && reg_addr == 8'h08;
  a_err_upper_zero: assert property (
    reg_rd && reg_addr == 8'h0a |=> reg_rdata[7:5] == 3'b000) else $error("err upper bits");
  a_ctrl_reads_zero: assert property (
    reg_rd && reg_addr == 8'h08 |=> !reg_rdata[7] && reg_rdata[3:2] == 2'b00)
    else $error("ctrl strobe bits read back");
  a_irq_sets: assert property (irq_event |=> lin_irq_pending) else $error("irq not set");
  a_irq_holds: assert property (
    lin_irq_pending && !(ctrl_wr && reg_wdata[3]) |=> lin_irq_pending) else $error("irq lost");
  a_irq_readback: assert property (
    reg_rd && reg_addr == 8'h09 |=> reg_rdata[3] == $past(lin_irq_pending))
    else $error("status bit3 mismatch");
  a_stop_pulse: assert property (
    ctrl_wr && reg_wdata[7] |=> stop_request ##1 !stop_request) else $error("stop pulse");
  a_ack_sets: assert property (
    ctrl_wr && reg_wdata[4] |=> data_acknowledge_bit) else $error("ack not set");
  a_ack_clears: assert property (
    data_acknowledge_bit && ack_consumed && !ctrl_wr |=> !data_acknowledge_bit)
    else $error("ack not cleared");
  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  c_stop: cover property (stop_request);
  c_ack_used: cover property (data_acknowledge_bit && ack_consumed);
  c_irq_clear: cover property (lin_irq_pending ##1 !lin_irq_pending);
endmodule
bind lse_status_flags lse_monitor i_mon (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .irq_event, .ack_consumed, .data_acknowledge_bit, .stop_request,
  .lin_irq_pending);

// >>> test/test_lse_status_flags.sv
// Self-checking bench for the LIN status and error flag block.
`timescale 1ns/1ps
module test_lse_status_flags import lse_pkg::*;;
  logic clk, rst_n, reg_wr, reg_rd, slave_mode, frame_start, frame_end, bit_tick;
  logic id_received, first_byte_done, ack_consumed, irq_event, tx_start, tx_complete;
  logic wakeup_tx_active, wakeup_rx, sync_tol_fail, parity_fail, master_no_response;
  logic slave_no_data, checksum_valid, tx_active, bit_sample, tx_bit, lin_rx_pin, corrupt;
  logic data_acknowledge_bit, stop_request, lin_irq_pending;
  logic [7:0] reg_addr, reg_wdata, checksum_received, checksum_computed;
  lse_byte_t reg_rdata;
  int n_fail, n_tests, cyc;
  lse_byte_t ef[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h04, 8'h04, 8'h04, 8'h00};
  lse_byte_t st[9] = '{8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h0c, 8'h1c, 8'h0c, 8'h00};
  lse_status_flags i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .slave_mode, .frame_start, .frame_end, .bit_tick, .id_received, .first_byte_done,
    .ack_consumed, .irq_event, .tx_start, .tx_complete, .wakeup_tx_active, .wakeup_rx,
    .sync_tol_fail, .parity_fail, .master_no_response, .slave_no_data, .checksum_valid,
    .checksum_received, .checksum_computed, .tx_active, .bit_sample, .tx_bit, .lin_rx_pin,
    .data_acknowledge_bit, .stop_request, .lin_irq_pending);
  lse_bus_node i_node (.tx_active, .tx_bit, .corrupt, .lin_rx_pin);
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1;
    @(posedge clk);
    #1 s = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    pulse(reg_wr);
  endtask
  task automatic rd(input logic [7:0] a, input lse_byte_t exp);
    reg_addr = a;
    pulse(reg_rd);
    n_tests++;
    if (reg_rdata !== exp) begin
      n_fail++;
      $display("[FAIL] %0t addr %h got %h exp %h", $time, a, reg_rdata, exp);
    end
  endtask
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t output got %b exp %b", $time, got, exp);
    end
  endtask
  // Cases 0-7 each raise one error source inside a frame, then clear it in two steps; case 8 drives parity in master mode, which raises none.
  task automatic err_case(input int k);
    slave_mode = !(k == 2 || k == 8);
    pulse(frame_start);
    case (k)
      0: begin
        tx_active = 1;
        corrupt = 1;
        repeat (3) @(posedge clk);
        pulse(bit_sample);
        tx_active = 0;
        corrupt = 0;
      end
      1: begin
        checksum_received = 8'h5a;
        checksum_computed = 8'ha5;
        pulse(checksum_valid);
      end
      2: pulse(master_no_response);
      3: pulse(parity_fail);
      4: pulse(sync_tol_fail);
      5: pulse(slave_no_data);
      6: begin
        pulse(id_received);
        pulse(first_byte_done);
      end
      7: begin
        repeat (173) pulse(bit_tick);
        rd(8'h0a, 8'h00);
        repeat (2) pulse(bit_tick);
      end
      default: pulse(parity_fail);
    endcase
    rd(8'h0a, ef[k]);
    rd(8'h09, st[k]);
    wr(8'h08, 8'h08);
    rd(8'h09, st[k] & 8'hf7);
    wr(8'h08, 8'h04);
    rd(8'h09, st[k] & 8'h10);
    rd(8'h0a, 8'h00);
    pulse(frame_end);
  endtask
  initial begin
    {rst_n, reg_wr, reg_rd, slave_mode, frame_start, frame_end, bit_tick, id_received,
      first_byte_done, ack_consumed, irq_event, tx_start, tx_complete, wakeup_tx_active,
      wakeup_rx, sync_tol_fail, parity_fail, master_no_response, slave_no_data,
      checksum_valid, tx_active, bit_sample, tx_bit, corrupt, reg_addr, reg_wdata,
      checksum_received, checksum_computed} = '0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    rd(8'h0a, 8'h00);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'h00);
    rd(8'h20, 8'h00);
    for (int k = 0; k < 9; k++) err_case(k);
    pulse(irq_event);
    chk(lin_irq_pending, 1'b1);
    wr(8'h08, 8'h00);
    rd(8'h09, 8'h08);
    wr(8'h08, 8'h08);
    chk(lin_irq_pending, 1'b0);
    rd(8'h09, 8'h00);
    wakeup_tx_active = 1;
    rd(8'h09, 8'h02);
    wakeup_tx_active = 0;
    rd(8'h09, 8'h00);
    pulse(wakeup_rx);
    rd(8'h09, 8'h02);
    pulse(tx_start);
    pulse(tx_complete);
    rd(8'h09, 8'h0b);
    pulse(tx_start);
    rd(8'h09, 8'h0a);
    slave_mode = 1;
    pulse(frame_start);
    wr(8'h08, 8'h08);
    rd(8'h09, 8'h00);
    pulse(id_received);
    rd(8'h09, 8'h18);
    wr(8'h08, 8'h10);
    chk(data_acknowledge_bit, 1'b1);
    rd(8'h08, 8'h10);
    pulse(first_byte_done);
    pulse(ack_consumed);
    rd(8'h08, 8'h00);
    pulse(id_received);
    wr(8'h08, 8'h80);
    chk(stop_request, 1'b1);
    pulse(first_byte_done);
    rd(8'h0a, 8'h00);
    pulse(parity_fail);
    rd(8'h0a, 8'h08);
    rst_n = 0;
    @(posedge clk);
    #1 rst_n = 1;
    chk(lin_irq_pending, 1'b0);
    rd(8'h0a, 8'h00);
    rd(8'h09, 8'h00);
    final_report;
  end
endmodule
